// ### sbt_pkg.sv
package sbt_pkg;
  localparam int SBT_NUM_CMP = 10;
  localparam int SBT_CMP_W = 4;
  localparam int SBT_NUM_SLOT = 4;
  localparam logic [SBT_CMP_W-1:0] SBT_CMP_NONE = 4'hF;
  localparam int SBT_CNT_W = 8;
  localparam logic [SBT_CNT_W-1:0] SBT_PASS_DEFAULT = 8'hFF;
  localparam int SBT_ADDR_W = 32;
  localparam int SBT_DATA_W = 32;
  localparam int SBT_TRACE_DEPTH = 256;
  localparam int SBT_TRACE_AW = 8;
  localparam int SBT_TIMER_W = 32;
  localparam int SBT_CLK_MHZ = 200;
  localparam int SBT_INTERVAL_US = 50;
  localparam logic [SBT_TIMER_W-1:0] SBT_INTERVAL_DEFAULT =
    SBT_TIMER_W'(SBT_INTERVAL_US * SBT_CLK_MHZ);
  localparam logic [SBT_TIMER_W-1:0] SBT_TIMER_ONE = 32'h0000_0001;
  localparam logic [SBT_CNT_W-1:0] SBT_CNT_ONE = 8'h01;
  localparam logic [SBT_TRACE_AW-1:0] SBT_PTR_ONE = 8'h01;
  localparam int SBT_SLOT_A = 0;
  localparam int SBT_SLOT_B = 1;
  localparam int SBT_SLOT_C = 2;
  localparam int SBT_SLOT_D = 3;

  typedef enum logic [2:0] {
    SBT_COND_ANY = 3'h1,
    SBT_COND_A_B = 3'h2,
    SBT_COND_A_B_C = 3'h3,
    SBT_COND_A_BC = 3'h4,
    SBT_COND_AB_C = 3'h5,
    SBT_COND_TIME = 3'h6
  } sbt_cond_e;

  typedef enum logic [1:0] {
    SBT_ST_IDLE = 2'b00,
    SBT_ST_ARM1 = 2'b01,
    SBT_ST_ARM2 = 2'b10
  } sbt_stage_e;

  typedef struct packed {
    logic valid;
    logic fetch;
    logic [SBT_ADDR_W-1:0] addr;
    logic [SBT_DATA_W-1:0] data;
  } sbt_cycle_s;

  typedef struct packed {
    logic marker;
    logic fetch;
    logic [SBT_ADDR_W-1:0] addr;
    logic [SBT_DATA_W-1:0] data;
  } sbt_trace_s;

  typedef struct packed {
    logic enable;
    sbt_cond_e cond;
    logic [SBT_NUM_SLOT-1:0][SBT_CMP_W-1:0] slot_map;
    logic [SBT_CNT_W-1:0] pass_count;
    logic [SBT_TIMER_W-1:0] interval;
  } sbt_cfg_s;
endpackage

// ### sbt_slot_match.sv
`timescale 1ns/100ps
module sbt_slot_match
  import sbt_pkg::*;
(
  input wire logic [SBT_CMP_W-1:0] i_map,
  input wire logic [SBT_NUM_CMP-1:0] i_hits,
  output logic o_match
);
  // an out-of-range index, including the none code, never matches
  always_comb begin
    o_match = 1'b0;
    if (i_map < SBT_CMP_W'(SBT_NUM_CMP)) begin
      o_match = i_hits[i_map];
    end
  end
endmodule

// ### sbt_trigger.sv
`timescale 1ns/100ps
// Contract
// - host selects one of six sequence conditions deciding slot combination.
// - condition two: A arms, B while armed fires, C disarms.
// - condition three: A arms, B arms next, C fires, D resets.
// - condition four: A arms, B or C fires, D disarms.
// - condition five: A or B arms, C fires, D disarms.
// - condition six: A to B interval above threshold fires an event.
// - count events; halt target when programmed pass count is reached.
// - report which comparator caused the halt; sequence halts report the slot A comparator instead.
// - capture fetches and memory cycles into trace in time order.
// - mark the trace entry of the breakpoint cycle.
// - cache enabled only by target signal, control bit and run field.
// - run command cache enable defaults to disabled.
// - sequence comparators only feed sequence; other active comparators halt independently.
module sbt_trigger
  import sbt_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire sbt_pkg::sbt_cfg_s i_cfg,
  input wire logic [sbt_pkg::SBT_NUM_CMP-1:0] i_cmp_active,
  input wire logic [sbt_pkg::SBT_NUM_CMP-1:0] i_cmp_hit,
  input wire sbt_pkg::sbt_cycle_s i_cycle,
  input wire logic i_run,
  input wire logic i_run_cache_en,
  input wire logic i_tgt_cache_ok,
  input wire logic i_cacr_lsb,
  input wire logic [sbt_pkg::SBT_TRACE_AW-1:0] i_trace_raddr,
  output sbt_pkg::sbt_trace_s o_trace_rdata,
  output logic [sbt_pkg::SBT_TRACE_AW-1:0] o_trace_wptr,
  output logic o_trace_wrapped,
  output logic o_halt,
  output logic o_halt_seq,
  output logic [sbt_pkg::SBT_CMP_W-1:0] o_halt_cmp,
  output logic [sbt_pkg::SBT_CNT_W-1:0] o_event_count,
  output logic o_cache_en
);
  import sbt_pkg::*;

  typedef struct packed {
    sbt_stage_e stage;
    logic timing;
    logic [SBT_TIMER_W-1:0] timer;
    logic [SBT_CNT_W-1:0] count;
    logic halt;
    logic halt_seq;
    logic [SBT_CMP_W-1:0] halt_cmp;
    logic run_cache;
    logic cache_en;
    logic [SBT_TRACE_AW-1:0] wptr;
    logic wrapped;
    sbt_trace_s rdata;
  } sbt_state_s;

  sbt_state_s st;
  sbt_state_s next_st;
  sbt_trace_s trace_mem [SBT_TRACE_DEPTH];

  logic [SBT_NUM_SLOT-1:0] slot_hit;
  logic [SBT_NUM_CMP-1:0] in_seq;
  logic [SBT_NUM_CMP-1:0] solo_hit;
  logic seq_event;
  logic solo_any;
  logic [SBT_CMP_W-1:0] solo_idx;
  logic bus_ok;
  logic halt_now;

  genvar g;
  generate
    for (g = 0; g < SBT_NUM_SLOT; g++) begin : g_slot
      sbt_slot_match u_match (
        .i_map(i_cfg.slot_map[g]),
        .i_hits(i_cmp_hit),
        .o_match(slot_hit[g])
      );
    end
  endgenerate

  assign bus_ok = i_cycle.valid && !st.halt;

  // comparators mapped into the enabled sequence are withheld from halting, armed or not
  always_comb begin
    in_seq = '0;
    for (int s = 0; s < SBT_NUM_SLOT; s++) begin
      if (i_cfg.enable && i_cfg.slot_map[s] < SBT_CMP_W'(SBT_NUM_CMP)) begin
        in_seq[i_cfg.slot_map[s]] = 1'b1;
      end
    end
    solo_hit = i_cmp_hit & i_cmp_active & ~in_seq;
    solo_any = 1'b0;
    solo_idx = '0;
    for (int c = SBT_NUM_CMP - 1; c >= 0; c--) begin
      if (solo_hit[c]) begin
        solo_any = 1'b1;
        solo_idx = SBT_CMP_W'(c);
      end
    end
  end

  always_comb begin
    next_st = st;
    seq_event = 1'b0;
    halt_now = 1'b0;
    if (i_run) begin
      next_st.run_cache = i_run_cache_en;
      next_st.halt = 1'b0;
      next_st.halt_seq = 1'b0;
      next_st.count = '0;
    end
    if (st.timing) begin
      next_st.timer = st.timer + SBT_TIMER_ONE;
    end
    if (bus_ok && i_cfg.enable) begin
      case (i_cfg.cond)
        SBT_COND_ANY: begin
          seq_event = |slot_hit;
        end
        SBT_COND_A_B: begin
          if (slot_hit[SBT_SLOT_C]) begin
            next_st.stage = SBT_ST_IDLE;
          end else if (st.stage == SBT_ST_ARM1 && slot_hit[SBT_SLOT_B]) begin
            seq_event = 1'b1;
            next_st.stage = SBT_ST_IDLE;
          end else if (slot_hit[SBT_SLOT_A]) begin
            next_st.stage = SBT_ST_ARM1;
          end
        end
        SBT_COND_A_B_C: begin
          if (slot_hit[SBT_SLOT_D]) begin
            next_st.stage = SBT_ST_IDLE;
          end else if (st.stage == SBT_ST_ARM2 && slot_hit[SBT_SLOT_C]) begin
            seq_event = 1'b1;
            next_st.stage = SBT_ST_IDLE;
          end else if (st.stage == SBT_ST_ARM1 && slot_hit[SBT_SLOT_B]) begin
            next_st.stage = SBT_ST_ARM2;
          end else if (st.stage == SBT_ST_IDLE && slot_hit[SBT_SLOT_A]) begin
            next_st.stage = SBT_ST_ARM1;
          end
        end
        SBT_COND_A_BC: begin
          if (slot_hit[SBT_SLOT_D]) begin
            next_st.stage = SBT_ST_IDLE;
          end else if (st.stage == SBT_ST_ARM1 &&
                       (slot_hit[SBT_SLOT_B] || slot_hit[SBT_SLOT_C])) begin
            seq_event = 1'b1;
            next_st.stage = SBT_ST_IDLE;
          end else if (slot_hit[SBT_SLOT_A]) begin
            next_st.stage = SBT_ST_ARM1;
          end
        end
        SBT_COND_AB_C: begin
          if (slot_hit[SBT_SLOT_D]) begin
            next_st.stage = SBT_ST_IDLE;
          end else if (st.stage == SBT_ST_ARM1 && slot_hit[SBT_SLOT_C]) begin
            seq_event = 1'b1;
            next_st.stage = SBT_ST_IDLE;
          end else if (slot_hit[SBT_SLOT_A] || slot_hit[SBT_SLOT_B]) begin
            next_st.stage = SBT_ST_ARM1;
          end
        end
        SBT_COND_TIME: begin
          // a B match closes the window; a fresh A restarts it
          if (st.timing && slot_hit[SBT_SLOT_B]) begin
            seq_event = (st.timer > i_cfg.interval);
            next_st.timing = 1'b0;
            next_st.timer = '0;
          end else if (slot_hit[SBT_SLOT_A]) begin
            next_st.timing = 1'b1;
            next_st.timer = '0;
          end
        end
        default: begin
          next_st.stage = SBT_ST_IDLE;
        end
      endcase
    end
    if (seq_event) begin
      // a run in this cycle has already zeroed next_st.count
      next_st.count = next_st.count + SBT_CNT_ONE;
      if (next_st.count >= i_cfg.pass_count) begin
        halt_now = 1'b1;
        next_st.halt_seq = 1'b1;
        next_st.halt_cmp = i_cfg.slot_map[SBT_SLOT_A];
      end
    end
    if (bus_ok && solo_any && !halt_now) begin
      halt_now = 1'b1;
      next_st.halt_cmp = solo_idx;
      next_st.halt_seq = 1'b0;
    end
    if (halt_now) begin
      next_st.halt = 1'b1;
      next_st.stage = SBT_ST_IDLE;
      next_st.timing = 1'b0;
      next_st.timer = '0;
      next_st.count = '0;
    end
    if (bus_ok) begin
      next_st.wptr = st.wptr + SBT_PTR_ONE;
      if (st.wptr == SBT_TRACE_AW'(SBT_TRACE_DEPTH - 1)) begin
        next_st.wrapped = 1'b1;
      end
    end
    next_st.cache_en = st.run_cache && i_tgt_cache_ok && i_cacr_lsb;
    next_st.rdata = trace_mem[i_trace_raddr];
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      st <= '0;
      st.stage <= SBT_ST_IDLE;
      st.run_cache <= 1'b0;
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  // entries are written in bus order, the halting cycle carries the marker
  always_ff @(posedge i_ref_clk) begin
    if (i_ce && bus_ok) begin
      trace_mem[st.wptr] <= '{marker: halt_now, fetch: i_cycle.fetch,
                              addr: i_cycle.addr,
                              data: i_cycle.data};
    end
  end

  assign o_trace_rdata = st.rdata;
  assign o_trace_wptr = st.wptr;
  assign o_trace_wrapped = st.wrapped;
  assign o_halt = st.halt;
  assign o_halt_seq = st.halt_seq;
  assign o_halt_cmp = st.halt_cmp;
  assign o_event_count = st.count;
  assign o_cache_en = st.cache_en;

  a_cache_gate: assert property (
    @(posedge i_ref_clk) disable iff (i_srst)
    $past(i_ce) && o_cache_en |-> $past(i_tgt_cache_ok) &&
    $past(i_cacr_lsb) && $past(st.run_cache))
    else $error("cache enabled without all three permits");
  a_cache_off: assert property (
    @(posedge i_ref_clk)
    $past(i_srst) |-> !o_cache_en && !st.run_cache)
    else $error("cache permit not cleared by reset");
  a_halt_clears: assert property (
    @(posedge i_ref_clk) disable iff (i_srst)
    i_ce && halt_now |=> st.stage == SBT_ST_IDLE && !st.timing &&
    o_event_count == '0)
    else $error("sequencer not cleared on halt");
  a_halt_sets: assert property (
    @(posedge i_ref_clk) disable iff (i_srst)
    i_ce && halt_now |=> o_halt)
    else $error("halt not raised");
  a_halt_holds: assert property (
    @(posedge i_ref_clk) disable iff (i_srst)
    o_halt && !i_run && i_ce |=> o_halt)
    else $error("halt dropped without run");
  a_run_clears: assert property (
    @(posedge i_ref_clk) disable iff (i_srst)
    i_ce && i_run && !halt_now |=> !o_halt && !o_halt_seq)
    else $error("run did not clear the halt");
  a_trace_order: assert property (
    @(posedge i_ref_clk) disable iff (i_srst)
    i_ce && bus_ok |=> o_trace_wptr == $past(o_trace_wptr) + SBT_PTR_ONE)
    else $error("trace pointer skipped");
  a_marker: assert property (
    @(posedge i_ref_clk) disable iff (i_srst)
    i_ce && bus_ok |=> trace_mem[$past(st.wptr)].marker == $past(halt_now))
    else $error("trace marker does not match the halting cycle");
  a_wrap_sticky: assert property (
    @(posedge i_ref_clk) disable iff (i_srst)
    o_trace_wrapped |=> o_trace_wrapped)
    else $error("trace wrap flag dropped");
  a_ce_freeze: assert property (
    @(posedge i_ref_clk) disable iff (i_srst)
    !i_ce |=> $stable(o_trace_wptr) && $stable(o_halt) &&
    $stable(o_event_count))
    else $error("state moved while clock enable was low");
  a_cond_any: assert property (
    @(posedge i_ref_clk) disable iff (i_srst)
    i_ce && !i_run && bus_ok && i_cfg.enable &&
    i_cfg.cond == SBT_COND_ANY && |slot_hit |=>
    o_halt || o_event_count == $past(o_event_count) + SBT_CNT_ONE)
    else $error("any-slot event not counted");
  a_arm_two: assert property (
    @(posedge i_ref_clk) disable iff (i_srst)
    i_ce && bus_ok && i_cfg.enable && i_cfg.cond == SBT_COND_A_B &&
    slot_hit[SBT_SLOT_C] && !halt_now |=> st.stage == SBT_ST_IDLE)
    else $error("C did not disarm");
  a_seq_mask: assert property (
    @(posedge i_ref_clk) disable iff (i_srst)
    i_ce && !o_halt && !seq_event &&
    !(|(i_cmp_hit & i_cmp_active & ~in_seq)) |=> !o_halt)
    else $error("sequence comparator halting alone");
  a_time_short: assert property (
    @(posedge i_ref_clk) disable iff (i_srst)
    i_ce && !i_run && bus_ok && !solo_any && i_cfg.enable &&
    i_cfg.cond == SBT_COND_TIME && st.timing && slot_hit[SBT_SLOT_B] &&
    st.timer <= i_cfg.interval |=>
    !o_halt && o_event_count == $past(o_event_count))
    else $error("short interval raised an event");
  a_pass_reach: assert property (
    @(posedge i_ref_clk) disable iff (i_srst)
    i_ce && !i_run && seq_event &&
    o_event_count + SBT_CNT_ONE == i_cfg.pass_count |=> o_halt && o_halt_seq)
    else $error("pass count reached without a halt");
  a_unmapped: assert property (
    @(posedge i_ref_clk) disable iff (i_srst)
    i_cfg.slot_map[SBT_SLOT_B] == SBT_CMP_NONE |-> !slot_hit[SBT_SLOT_B])
    else $error("unmapped slot matched");
endmodule

// ### sbt_tgt_model.sv
`timescale 1ns/100ps
// target bus side: presents one bus cycle while i_req is high
module sbt_tgt_model (
  input wire logic i_clk,
  input wire logic i_req,
  input wire logic [sbt_pkg::SBT_NUM_CMP-1:0] i_hits,
  input wire logic [sbt_pkg::SBT_ADDR_W-1:0] i_addr,
  output sbt_pkg::sbt_cycle_s o_cycle,
  output logic [sbt_pkg::SBT_NUM_CMP-1:0] o_hits
);
  import sbt_pkg::*;
  sbt_cycle_s last = '0;
  logic [SBT_NUM_CMP-1:0] last_hits = '0;
  always @(posedge i_clk) begin
    last <= o_cycle;
    last_hits <= o_hits;
  end
  // idle lines flip every cycle so a design that ignores valid shows up
  always_comb begin
    o_cycle.valid = i_req;
    o_cycle.fetch = i_req ? i_addr[2] : ~last.fetch;
    o_cycle.addr = i_req ? i_addr : ~last.addr;
    o_cycle.data = i_req ? ~i_addr : ~last.data;
    o_hits = i_req ? i_hits : ~last_hits;
  end
endmodule

// ### tb_sequential_breakpoint_trigger.sv
`timescale 1ns/100ps
module tb_sequential_breakpoint_trigger;
  import sbt_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_ce = 1'b1;
  sbt_cfg_s cfg = '0;
  logic [SBT_NUM_CMP-1:0] act = '0;
  logic req = 1'b0;
  logic [SBT_NUM_CMP-1:0] hits = '0;
  logic [SBT_ADDR_W-1:0] addr = '0;
  logic [SBT_ADDR_W-1:0] last_a = '0;
  sbt_cycle_s cyc_w;
  logic [SBT_NUM_CMP-1:0] hit_w;
  logic run = 1'b0;
  logic run_ce = 1'b0;
  logic tgt_ok = 1'b0;
  logic lsb = 1'b0;
  logic [SBT_TRACE_AW-1:0] raddr = '0;
  sbt_trace_s rdata;
  logic [SBT_TRACE_AW-1:0] wptr;
  logic [SBT_TRACE_AW-1:0] w;
  logic wrapped;
  logic halt, halt_seq, cache_en;
  logic [SBT_CMP_W-1:0] halt_cmp;
  logic [SBT_CNT_W-1:0] ev_cnt;
  int n_errors = 0;
  int tests_run = 0;
  int ticks = 0;
  // row: condition, up to four slot masks in order (0 = none), halt
  localparam logic [23:0] ROWS [13] = '{24'h1_2000_1, 24'h1_8000_1,
    24'h2_1200_1, 24'h2_1420_0, 24'h2_2000_0, 24'h3_1240_1,
    24'h3_1284_0, 24'h4_1400_1, 24'h4_1820_0, 24'h5_2400_1, 24'h5_1840_0,
    24'h0_1200_0, 24'h7_1200_0};

  sbt_tgt_model tgt (.i_clk(i_ref_clk), .i_req(req), .i_hits(hits),
    .i_addr(addr), .o_cycle(cyc_w), .o_hits(hit_w));
  sbt_trigger dut (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_ce(i_ce),
    .i_cfg(cfg), .i_cmp_active(act), .i_cmp_hit(hit_w), .i_cycle(cyc_w),
    .i_run(run), .i_run_cache_en(run_ce), .i_tgt_cache_ok(tgt_ok),
    .i_cacr_lsb(lsb), .i_trace_raddr(raddr), .o_trace_rdata(rdata),
    .o_trace_wptr(wptr), .o_trace_wrapped(wrapped), .o_halt(halt),
    .o_halt_seq(halt_seq), .o_halt_cmp(halt_cmp),
    .o_event_count(ev_cnt), .o_cache_en(cache_en));

  initial forever #2.5 i_ref_clk = ~i_ref_clk;

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge i_ref_clk) begin
    ticks = ticks + 1;
    if (ticks == 20000) begin
      n_errors = n_errors + 1;
      finish_test();
    end
  end

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic cyc(input logic [9:0] h);
    @(negedge i_ref_clk);
    req = 1'b1;
    hits = h;
    addr = last_a + 32'h0000_0004;
    last_a = addr;
    @(negedge i_ref_clk);
    req = 1'b0;
  endtask

  task automatic pulse_run();
    @(negedge i_ref_clk);
    run = 1'b1;
    @(negedge i_ref_clk);
    run = 1'b0;
  endtask

  task automatic do_rst();
    @(negedge i_ref_clk);
    i_srst = 1'b1;
    repeat (3) @(negedge i_ref_clk);
    i_srst = 1'b0;
  endtask

  // each case starts from reset so arm stages never leak between rows
  task automatic setup(input logic [2:0] c, input logic [7:0] p);
    do_rst();
    cfg.enable = 1'b1;
    cfg.cond = sbt_cond_e'(c);
    cfg.pass_count = p;
    cfg.slot_map = 16'h3210;
    cfg.interval = 32'h0000_000A;
    act = 10'h00F;
    pulse_run();
  endtask

  initial begin
    repeat (3) @(negedge i_ref_clk);
    i_srst = 1'b0;
    for (int i = 0; i < 13; i++) begin
      setup(ROWS[i][22:20], 8'h01);
      for (int k = 3; k >= 0; k--) begin
        if (ROWS[i][4+4*k+:4] != 4'h0) cyc({6'h00, ROWS[i][4+4*k+:4]});
      end
      chk(halt, ROWS[i][0]);
      if (ROWS[i][0]) begin
        chk(halt_seq, 1'b1);
        chk(halt_cmp, 4'h0);
        raddr = wptr - SBT_PTR_ONE;
        repeat (2) @(negedge i_ref_clk);
        chk(rdata.marker, 1'b1);
        chk(rdata.addr, last_a);
        chk(rdata.data, SBT_DATA_W'(~last_a));
        chk(rdata.fetch, last_a[2]);
      end
      $display("row %0d done", i);
    end
    setup(3'h6, 8'h01);
    cyc(10'h002);
    cyc(10'h001);
    repeat (5) @(negedge i_ref_clk);
    cyc(10'h002);
    chk(halt, 1'b0);
    cyc(10'h001);
    repeat (15) @(negedge i_ref_clk);
    cyc(10'h002);
    chk(halt, 1'b1);
    $display("interval test done");
    setup(3'h3, 8'h02);
    cyc(10'h001);
    cyc(10'h002);
    cyc(10'h004);
    chk(ev_cnt, 8'h01);
    chk(halt, 1'b0);
    cyc(10'h001);
    cyc(10'h002);
    cyc(10'h004);
    chk(halt, 1'b1);
    chk(ev_cnt, 8'h00);
    w = wptr;
    cyc(10'h001);
    chk(wptr, w);
    pulse_run();
    cyc(10'h004);
    chk(halt, 1'b0);
    $display("pass count test done");
    setup(3'h2, 8'h01);
    cfg.slot_map[SBT_SLOT_B] = SBT_CMP_NONE;
    act = 10'h021;
    cyc(10'h001);
    cyc(10'h002);
    chk(halt, 1'b0);
    i_ce = 1'b0;
    w = wptr;
    cyc(10'h020);
    i_ce = 1'b1;
    chk(wptr, w);
    chk(halt, 1'b0);
    cyc(10'h020);
    chk(halt, 1'b1);
    chk(halt_seq, 1'b0);
    chk(halt_cmp, 4'h5);
    $display("independent halt test done");
    do_rst();
    @(negedge i_ref_clk);
    chk(halt, 1'b0);
    chk(wptr, 8'h00);
    chk(ev_cnt, 8'h00);
    for (int n = 0; n < 255; n++) cyc(10'h000);
    chk(wrapped, 1'b0);
    chk(wptr, 8'hFF);
    cyc(10'h000);
    chk(wrapped, 1'b1);
    chk(wptr, 8'h00);
    cfg.enable = 1'b0;
    act = 10'h001;
    cyc(10'h001);
    chk(halt, 1'b1);
    chk(halt_seq, 1'b0);
    chk(halt_cmp, 4'h0);
    $display("reset and wrap test done");
    tgt_ok = 1'b1;
    lsb = 1'b1;
    do_rst();
    @(negedge i_ref_clk);
    @(negedge i_ref_clk);
    chk(cache_en, 1'b0);
    for (int m = 0; m < 8; m++) begin
      run_ce = m[0];
      tgt_ok = m[1];
      lsb = m[2];
      pulse_run();
      @(negedge i_ref_clk);
      chk(cache_en, m == 7);
    end
    $display("cache test done");
    finish_test();
  end
endmodule
